// ### src/ulpi_low_power_entry_exit.sv
// Low power entry, exit and interface protection of the transceiver side
`default_nettype none
//
// Contract
// RULE1 - Link clears low power bit to suspend
// RULE2 - Raise dir, five clock edges, then stop
// RULE3 - Mode 01 makes line pins high impedance
// RULE4 - Data 0 and 1 carry raw linestate
// RULE5 - Data 3 is active high wake interrupt
// RULE6 - Enabled comparator edges raise wake interrupt
// RULE7 - Low power bus driven without a clock
// RULE8 - Link raises stop to wake
// RULE9 - After start-up restart clock, then drop dir
// RULE10 - Link drops stop only after dir low
// RULE11 - Low power bit returns to one itself
// RULE12 - Early stop fall means false wake
// RULE13 - One idle turnaround cycle per dir change
// RULE14 - Link ready and idle when dir falls
// RULE15 - Unready link holds stop high meanwhile
// RULE16 - Link drives idle after receive command
// RULE17 - Link resets with stop high, bus released
// RULE18 - Stop pull-up on at power-on, bit disables
// RULE19 - Stop high while suspended wakes the device
// RULE20 - Unused vbus and session end comparators off
// RULE21 - Link re-enables comparators after waking
// RULE22 - Reset pin low disables stop pull-up
// RULE23 - Data 2 and 7 to 4 driven low
module ulpi_low_power_entry_exit
  import lp_pkg::*;
#(
  parameter int START_CNT = START_CYCLES
)(
  // Clock and reset
  input  wire logic                 ref_clk_i,
  input  wire logic                 nrst_i,
  input  wire logic                 reset_pin_n_i,
  // Register write path from the protocol block
  input  wire logic                 low_power_n_wr_i,
  input  wire logic                 low_power_n_wdata_i,
  input  wire logic                 stop_pullup_disable_i,
  input  wire logic [1:0]           op_mode_i,
  input  wire logic [NUM_CMP-1:0]   rise_en_i,
  input  wire logic [NUM_CMP-1:0]   fall_en_i,
  // Analog inputs
  input  wire logic [1:0]           linestate_i,
  input  wire logic [NUM_CMP-1:0]   cmp_i,
  // Link pins
  input  wire logic                 stp_i,
  output logic                      dir_o,
  output logic [7:0]                data_o,
  output logic [7:0]                data_oe_o,
  output logic                      phy_clock_output_o,
  // Status and analog controls
  output logic                      low_power_n_ctl_o,
  output logic                      low_power_o,
  output logic                      line_hiz_o,
  output logic                      stop_pullup_en_o,
  output logic                      vbus_cmp_en_o,
  output logic                      sess_end_cmp_en_o
);
  typedef enum logic [2:0] {ST_RUN, ST_ENTRY, ST_SLEEP, ST_START, ST_RELEASE} state_type;

  // ------------------------------------------------------------
  // Input synchronisers
  // ------------------------------------------------------------
  logic               stp_s;
  logic [NUM_CMP-1:0] cmp_s;

  lp_sync #(.W(1)) u_stp_sync
  (
    .ref_clk_i (ref_clk_i),
    .nrst_i    (nrst_i),
    .d_i       (stp_i),
    .q_o       (stp_s)
  );

  lp_sync #(.W(NUM_CMP)) u_cmp_sync
  (
    .ref_clk_i (ref_clk_i),
    .nrst_i    (nrst_i),
    .d_i       (cmp_i),
    .q_o       (cmp_s)
  );

  // ------------------------------------------------------------
  // Output clock divider
  // ------------------------------------------------------------
  state_type   state;
  logic [1:0]  div;
  logic        clk_run;
  logic        clk_rise;
  logic [2:0]  edge_cnt;
  logic [31:0] start_cnt;
  logic        turn;

  // Divider runs only while the output clock is live
  always_ff @(posedge ref_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      div <= 2'h0;
    else if (clk_run)
      div <= div + 2'h1;
    else
      div <= 2'h0;
  end

  assign clk_rise = clk_run && (div == 2'(CLK_DIV / 2 - 1));

  // Clock output high for half the period, held low when stopped
  always_ff @(posedge ref_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      phy_clock_output_o <= 1'b0;
    else
      phy_clock_output_o <= clk_run && (div[0] != div[1]);  // Rises on the same edge as clk_rise
  end

  // ------------------------------------------------------------
  // Low power sequencer
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      state     <= ST_RUN;
      edge_cnt  <= 3'h0;
      start_cnt <= 32'h0;
    end
    else
    begin
      case (state)
        ST_RUN:
        begin
          edge_cnt <= 3'h0;
          if (low_power_n_wr_i && !low_power_n_wdata_i)
            state <= ST_ENTRY;  // RULE1
        end
        ST_ENTRY:
        begin
          // Only rises seen after dir is already high count towards the minimum
          if (clk_rise && dir_o)
            edge_cnt <= edge_cnt + 3'h1;
          if (clk_rise && dir_o && edge_cnt == 3'(ENTRY_EDGES - 1))
            state <= ST_SLEEP;  // RULE2
        end
        ST_SLEEP:
        begin
          start_cnt <= 32'h0;
          if (stp_s)
            state <= ST_START;  // RULE8 RULE19
        end
        ST_START:
        begin
          start_cnt <= start_cnt + 32'h1;
          if (!stp_s)
            state <= ST_SLEEP;  // RULE12
          else if (start_cnt >= 32'(START_CNT - 1))
            state <= ST_RELEASE;
        end
        ST_RELEASE:
        begin
          if (!stp_s)
            state <= ST_SLEEP;  // RULE12
          else if (clk_rise)
            state <= ST_RUN;    // RULE9
        end
        default: state <= ST_RUN;
      endcase
    end
  end

  // Clock runs except while sleeping or starting up
  assign clk_run = (state == ST_RUN) || (state == ST_ENTRY) || (state == ST_RELEASE);  // RULE2 RULE9

  // ------------------------------------------------------------
  // Direction, turnaround and low power control bit
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      dir_o             <= 1'b0;
      turn              <= 1'b0;
      low_power_n_ctl_o <= LOW_POWER_N_RST;
    end
    else
    begin
      dir_o <= (state != ST_RUN);                     // RULE13
      turn  <= ((state != ST_RUN) != dir_o);          // RULE13
      if (state == ST_RELEASE && clk_rise && stp_s)
        low_power_n_ctl_o <= 1'b1;                    // RULE11
      else if (state == ST_RUN && low_power_n_wr_i)
        low_power_n_ctl_o <= low_power_n_wdata_i;
    end
  end

  assign low_power_o = (state == ST_SLEEP) || (state == ST_START);

  // ------------------------------------------------------------
  // Wake interrupt and data bus
  // ------------------------------------------------------------
  logic [NUM_CMP-1:0] cmp_ref;
  logic               wake_int;

  // Capture comparator levels when entering low power
  always_ff @(posedge ref_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      cmp_ref <= '0;
    else if (state == ST_ENTRY)
      cmp_ref <= cmp_s;
  end

  // Compared asynchronously against live comparators: no clock needed
  assign wake_int = |(((cmp_i & ~cmp_ref) & rise_en_i) | ((~cmp_i & cmp_ref) & fall_en_i));  // RULE5 RULE6

  // Bus drive while dir high, but not during the turnaround cycle
  always_comb
  begin
    data_o    = IDLE_BYTE;                         // RULE23
    data_oe_o = (dir_o && !turn) ? 8'hff : 8'h00;  // RULE13
    if (low_power_o)
    begin
      data_o[LS0_BIT]  = linestate_i[0];           // RULE4 RULE7
      data_o[LS1_BIT]  = linestate_i[1];           // RULE4
      data_o[WAKE_BIT] = wake_int;                 // RULE5
      data_oe_o        = 8'hff;
    end
  end

  // ------------------------------------------------------------
  // Analog controls
  // ------------------------------------------------------------
  assign line_hiz_o        = (op_mode_i == MODE_NONDRIVING);                             // RULE3
  assign stop_pullup_en_o  = reset_pin_n_i && !stop_pullup_disable_i;                    // RULE18 RULE22
  assign vbus_cmp_en_o     = rise_en_i[CMP_VBUS] || fall_en_i[CMP_VBUS];                 // RULE20
  assign sess_end_cmp_en_o = rise_en_i[CMP_SESS_END] || fall_en_i[CMP_SESS_END];         // RULE20
endmodule
`default_nettype wire

// ### src/lp_pkg.sv
// Constants shared by the low power entry and exit logic
`default_nettype none
package lp_pkg;
  // Clock and timing
  localparam int          CLK_MHZ          = 250;
  localparam int          ENTRY_EDGES      = 5;      // Least output clock edges before stopping
  localparam int          START_US         = 1;      // Start-up time after wake request
  localparam int          START_CYCLES     = START_US * CLK_MHZ;
  localparam int          CLK_DIV          = 4;      // System cycles per output clock period
  // Operating mode encodings
  localparam logic [1:0]  MODE_NONDRIVING  = 2'h1;
  // Data bus layout in low power mode
  localparam int          LS0_BIT          = 0;
  localparam int          LS1_BIT          = 1;
  localparam int          WAKE_BIT         = 3;
  // Interface control bit that turns off the stop pull-up
  localparam int          PULLUP_DIS_BIT   = 7;
  // Reset values
  localparam logic        LOW_POWER_N_RST  = 1'b1;
  localparam logic [7:0]  IDLE_BYTE        = 8'h00;
  // Comparator vector positions
  localparam int          CMP_VBUS         = 0;
  localparam int          CMP_SESS_VLD     = 1;
  localparam int          CMP_SESS_END     = 2;
  localparam int          CMP_ID_GND       = 3;
  localparam int          NUM_CMP          = 4;
endpackage
`default_nettype wire

// ### src/lp_sync.sv
// Two flip-flop synchroniser for a level
`default_nettype none
module lp_sync
  import lp_pkg::*;
#(
  parameter int W = 1
)(
  // Clock and reset
  input  wire logic         ref_clk_i,
  input  wire logic         nrst_i,
  // Level in and out
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta;

  // Two stage capture; first stage read only by the second
  always_ff @(posedge ref_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      meta <= '0;
      q_o  <= '0;
    end
    else
    begin
      meta <= d_i;
      q_o  <= meta;
    end
  end
endmodule
`default_nettype wire

// ### sim/ulpi_link_model.sv
// Link side model that drives stop and watches dir
`default_nettype none
module ulpi_link_model (
  // Clock and link reset
  input  wire logic ref_clk_i,
  input  wire logic link_nrst_i,
  // Commands from the bench
  input  wire logic wake_i,
  input  wire logic early_i,
  input  wire logic slow_i,
  // Link pins
  input  wire logic dir_i,
  output var  logic stp_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Stop is high in reset, raised to wake, dropped once dir is low and start-up is done
  always_ff @(posedge ref_clk_i or negedge link_nrst_i)
    if (!link_nrst_i)
      stp_o <= 1'b1;
    else if (wake_i)
      stp_o <= 1'b1;
    else if (early_i || (!dir_i && !slow_i))
      stp_o <= 1'b0;
endmodule
`default_nettype wire

// ### sim/ulpi_low_power_entry_exit_checker.sv
// Port assertions for the low power entry and exit block
`default_nettype none
module ulpi_low_power_entry_exit_checker
  import lp_pkg::*;
(
  // Clock and reset
  input wire logic               ref_clk_i,
  input wire logic               nrst_i,
  // Inputs
  input wire logic               reset_pin_n_i,
  input wire logic               low_power_n_wr_i,
  input wire logic               low_power_n_wdata_i,
  input wire logic               stop_pullup_disable_i,
  input wire logic [1:0]         op_mode_i,
  input wire logic [NUM_CMP-1:0] rise_en_i,
  input wire logic [NUM_CMP-1:0] fall_en_i,
  input wire logic [1:0]         linestate_i,
  // Outputs
  input wire logic               dir_o,
  input wire logic [7:0]         data_o,
  input wire logic [7:0]         data_oe_o,
  input wire logic               phy_clock_output_o,
  input wire logic               low_power_n_ctl_o,
  input wire logic               low_power_o,
  input wire logic               line_hiz_o,
  input wire logic               stop_pullup_en_o,
  input wire logic               vbus_cmp_en_o,
  input wire logic               sess_end_cmp_en_o
);
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);
  property p_entry; low_power_n_wr_i && !low_power_n_wdata_i && !dir_o |-> ##2 dir_o; endproperty
  a_entry: assert property (p_entry) else $error("dir late after entry");
  property p_stop; $rose(low_power_o) |=> !phy_clock_output_o && !low_power_n_ctl_o; endproperty
  a_stop: assert property (p_stop) else $error("clock or bit wrong at sleep");
  property p_hiz; line_hiz_o == (op_mode_i == MODE_NONDRIVING); endproperty
  a_hiz: assert property (p_hiz) else $error("line hiz wrong");
  property p_lines; low_power_o |-> data_o[1:0] == linestate_i; endproperty
  a_lines: assert property (p_lines) else $error("linestate not passed");
  property p_wake; low_power_o && data_o[WAKE_BIT] |-> (rise_en_i | fall_en_i) != 4'h0; endproperty
  a_wake: assert property (p_wake) else $error("wake while masked");
  property p_zero; low_power_o |-> !data_o[2] && data_o[7:4] == 4'h0; endproperty
  a_zero: assert property (p_zero) else $error("spare lines not low");
  property p_turn; $rose(dir_o) |-> data_oe_o == 8'h00 ##1 data_oe_o == 8'hff; endproperty
  a_turn: assert property (p_turn) else $error("turnaround wrong");
  property p_idle; !dir_o |-> data_oe_o == 8'h00; endproperty
  a_idle: assert property (p_idle) else $error("bus driven with dir low");
  property p_ctl; $fell(dir_o) |-> low_power_n_ctl_o; endproperty
  a_ctl: assert property (p_ctl) else $error("bit not restored");
  property p_clk; $fell(dir_o) |-> ##[0:4] $rose(phy_clock_output_o); endproperty
  a_clk: assert property (p_clk) else $error("clock not running");
  property p_pull; stop_pullup_en_o == (reset_pin_n_i && !stop_pullup_disable_i); endproperty
  a_pull: assert property (p_pull) else $error("pull-up wrong");
  property p_cmp;
    vbus_cmp_en_o == (rise_en_i[0] | fall_en_i[0]) && sess_end_cmp_en_o == (rise_en_i[2] | fall_en_i[2]);
  endproperty
  a_cmp: assert property (p_cmp) else $error("comparator enable wrong");
endmodule
bind ulpi_low_power_entry_exit ulpi_low_power_entry_exit_checker ulpi_low_power_entry_exit_checker_inst (
  .ref_clk_i, .nrst_i, .reset_pin_n_i, .low_power_n_wr_i, .low_power_n_wdata_i, .stop_pullup_disable_i,
  .op_mode_i, .rise_en_i, .fall_en_i, .linestate_i, .dir_o, .data_o, .data_oe_o, .phy_clock_output_o,
  .low_power_n_ctl_o, .low_power_o, .line_hiz_o, .stop_pullup_en_o, .vbus_cmp_en_o, .sess_end_cmp_en_o);
`default_nettype wire

// ### sim/ulpi_low_power_entry_exit_tb_top.sv
// Self-checking bench for the low power entry and exit block
`default_nettype none
module ulpi_low_power_entry_exit_tb_top
  import lp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SC = 8; // Short start-up count
  logic ref_clk_i = 0, nrst_i = 0, link_nrst = 0, reset_pin_n_i = 1, wake = 0, early = 0, slow = 0;
  logic low_power_n_wr_i = 0, low_power_n_wdata_i = 1, stop_pullup_disable_i = 0, stp_i;
  logic [1:0] op_mode_i = 2'h0, linestate_i = 2'h0;
  logic [NUM_CMP-1:0] rise_en_i = 4'h0, fall_en_i = 4'h0, cmp_i = 4'h0;
  logic dir_o, phy_clock_output_o, low_power_n_ctl_o, low_power_o, line_hiz_o;
  logic stop_pullup_en_o, vbus_cmp_en_o, sess_end_cmp_en_o;
  logic [7:0] data_o, data_oe_o;
  int miscompares = 0, checked = 0;
  ulpi_low_power_entry_exit #(.START_CNT(SC)) ulpi_low_power_entry_exit_inst (
    .ref_clk_i, .nrst_i, .reset_pin_n_i, .low_power_n_wr_i, .low_power_n_wdata_i, .stop_pullup_disable_i,
    .op_mode_i, .rise_en_i, .fall_en_i, .linestate_i, .cmp_i, .stp_i, .dir_o, .data_o, .data_oe_o,
    .phy_clock_output_o, .low_power_n_ctl_o, .low_power_o, .line_hiz_o, .stop_pullup_en_o,
    .vbus_cmp_en_o, .sess_end_cmp_en_o);
  ulpi_link_model ulpi_link_model_inst (.ref_clk_i, .link_nrst_i(link_nrst), .wake_i(wake),
    .early_i(early), .slow_i(slow), .dir_i(dir_o), .stp_o(stp_i));
  // Clock
  initial
    forever #2 ref_clk_i = ~ref_clk_i;
  // ----------------------------------------
  // Helpers and scenarios
  // ----------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask
  task automatic wait_dir_low();
    repeat (400)
    begin
      @(negedge ref_clk_i);
      if (dir_o === 1'b0)
        return;
    end
  endtask
  task automatic t_static();
    for (int m = 0; m < 4; m++)
    begin
      cyc(1);
      op_mode_i <= m[1:0];
      stop_pullup_disable_i <= m[0];
      reset_pin_n_i <= m[1];
      rise_en_i <= {1'b0, m[0], 1'b0, m[1]};
      fall_en_i <= {1'b0, m[1], 1'b0, m[0]};
      @(negedge ref_clk_i);
      chk({line_hiz_o, stop_pullup_en_o, vbus_cmp_en_o, sess_end_cmp_en_o}, {m == 1, m == 2, m != 0, m != 0});
    end
    cyc(1);
    rise_en_i <= 4'h0;
    fall_en_i <= 4'h0;
    $display("static done");
  endtask
  task automatic t_entry();
    int n;
    logic p;
    n = 0;
    cyc(1);
    low_power_n_wr_i <= 1'b1;
    low_power_n_wdata_i <= 1'b0;
    cyc(1);
    low_power_n_wr_i <= 1'b0;
    low_power_n_wdata_i <= 1'b1;
    @(negedge ref_clk_i);
    @(negedge ref_clk_i);
    chk(dir_o, 8'h01);
    p = phy_clock_output_o;
    repeat (100)
    begin
      @(negedge ref_clk_i);
      if (phy_clock_output_o && !p)
        n++;
      p = phy_clock_output_o;
      if (low_power_o === 1'b1)
        break;
    end
    chk(n >= 5, 8'h01);
    @(negedge ref_clk_i);
    chk({low_power_o, phy_clock_output_o, low_power_n_ctl_o, data_oe_o[0]}, 8'h09);
    for (int i = 0; i < 4; i++)
    begin
      cyc(1);
      linestate_i <= i[1:0];
      @(negedge ref_clk_i);
      chk(data_o, {6'h0, i[1:0]});
    end
    $display("entry done");
  endtask
  task automatic t_int();
    cyc(1);
    cmp_i[CMP_VBUS] <= 1'b1;
    cyc(5);
    chk(data_o[WAKE_BIT], 8'h00);
    rise_en_i[CMP_ID_GND] <= 1'b1;
    cmp_i[CMP_ID_GND] <= 1'b1;
    cyc(5);
    chk(data_o[WAKE_BIT], 8'h01);
    $display("interrupt done");
  endtask
  task automatic t_false();
    cyc(1);
    wake <= 1'b1;
    cyc(4);
    wake <= 1'b0;
    early <= 1'b1;
    cyc(1);
    early <= 1'b0;
    cyc(SC + 20);
    @(negedge ref_clk_i);
    chk({dir_o, low_power_o, phy_clock_output_o}, 8'h06);
    $display("false wake done");
  endtask
  task automatic t_exit(input logic warm);
    cyc(1);
    slow <= !warm;
    wake <= !warm;
    link_nrst <= !warm;
    cyc(2);
    wake <= 1'b0;
    link_nrst <= 1'b1;
    wait_dir_low();
    chk({dir_o, low_power_n_ctl_o, low_power_o, stp_i}, 8'h05);
    cyc(1);
    slow <= 1'b0;
    rise_en_i[CMP_VBUS] <= 1'b1;
    rise_en_i[CMP_SESS_END] <= 1'b1;
    cyc(3);
    chk(stp_i, 8'h00);
    chk({vbus_cmp_en_o, sess_end_cmp_en_o}, 8'h03);
    $display("exit done");
  endtask
  // Main sequence
  initial
  begin
    cyc(3);
    nrst_i <= 1'b1;
    link_nrst <= 1'b1;
    @(negedge ref_clk_i);
    chk({dir_o, phy_clock_output_o, low_power_n_ctl_o, stop_pullup_en_o, data_oe_o[0]}, 8'h06);
    t_static();
    t_entry();
    t_int();
    t_false();
    t_exit(1'b0);
    t_entry();
    t_exit(1'b1);
    give_verdict();
  end
  // Watchdog
  initial
  begin
    repeat (20000) @(posedge ref_clk_i);
    miscompares++;
    give_verdict();
  end
  task automatic give_verdict();
    $display("checked=%0d miscompares=%0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
endmodule
`default_nettype wire
